// [hdl/bdt_pkg.sv]
package bdt_pkg;

  // Timebase: one travel tick is 10 ms of motor time
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned TICK_MS       = 10;
  localparam int unsigned TICK_CYC_DEF  = TICK_MS * 1000000 / CLK_PERIOD_NS;

  // Reversal pauses, stretch-out times and the short step, in their own units
  localparam int unsigned PAUSE_MS   [0:4] = '{300, 500, 700, 1000, 1270};
  localparam int unsigned STRETCH_S  [0:3] = '{0, 2, 6, 30};
  localparam int unsigned STEP_MS          = 100;
  localparam logic [15:0] STEP_TK          = 16'(STEP_MS / TICK_MS);

  // Position is kept in ticks with this many fraction bits
  localparam int unsigned FRAC   = 10;
  localparam logic [9:0]  SLIP_K [0:12] = '{
    10'h000, 10'h002, 10'h004, 10'h006, 10'h008, 10'h00a, 10'h00f,
    10'h014, 10'h024, 10'h033, 10'h03f, 10'h052, 10'h080};

  // Register byte offsets
  localparam logic [7:0] REG_CFG  = 8'h00;
  localparam logic [7:0] REG_FULL = 8'h04;
  localparam logic [7:0] REG_SLAT = 8'h08;
  localparam logic [7:0] REG_CMD  = 8'h0c;
  localparam logic [7:0] REG_STAT = 8'h10;

  // Configuration fields
  localparam int unsigned CFG_PAUSE_LSB   = 0;
  localparam int unsigned CFG_SLIP_LSB    = 3;
  localparam int unsigned CFG_STRETCH_LSB = 7;
  localparam int unsigned CFG_AUTO_BIT    = 9;

  // Command fields
  localparam int unsigned CMD_MOVE   = 0;
  localparam int unsigned CMD_DIR    = 1;
  localparam int unsigned CMD_HEIGHT = 2;
  localparam int unsigned CMD_STOP   = 3;
  localparam int unsigned CMD_HT_LSB = 8;

  // Reset values: 0.5 s pause, no slip, no stretch, restoration on
  localparam logic [9:0]  CFG_RST  = 10'h201;
  localparam logic [15:0] FULL_RST = 16'h1770;
  localparam logic [15:0] SLAT_RST = 16'h00c8;

  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_RUN     = 6'h02,
    ST_STRETCH = 6'h04,
    ST_STEP    = 6'h08,
    ST_PAUSE   = 6'h10,
    ST_SLAT    = 6'h20
  } bdt_state_t;

endpackage : bdt_pkg

// [hdl/bdt_tick.sv]
`timescale 1ns/1ns
module bdt_tick #(
  parameter int unsigned TICK_CYC = 100000
) (
  input  wire logic core_clk,
  input  wire logic rst,
  output logic      tick
);

  logic [31:0] cnt_q;
  logic        tick_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q  <= 32'h0;
      tick_q <= 1'b0;
    end else if (cnt_q == 32'(TICK_CYC - 1)) begin
      cnt_q  <= 32'h0;
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 32'h1;
      tick_q <= 1'b0;
    end
  end

  assign tick = tick_q;

endmodule : bdt_tick

// [hdl/bdt_travel.sv]
// Summary of operation
// - Reversal stops, pauses configured interval, then reverses
// - Slippage: none or table percentage
// - Raising counts slower, reach target either way
// - After height move, optionally restore slat angle
// - Full down keeps relay on stretch-out time
// - Down at lower end: 100 ms step
// - Full down time scales all heights
// - Direction 1 lowers, 0 raises; 100% lowered
// - Direction LED follows energised relay
// - Up and down relays never together
`timescale 1ns/1ns
module bdt_travel
  import bdt_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYC_DEF
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        btn_up,
  input  wire logic        btn_down,
  output logic             relay_up,
  output logic             relay_down,
  output logic             led_up,
  output logic             led_down
);

  typedef struct packed {
    bdt_state_t  st;
    logic        dn;
    logic        full_mv;
    logic        slat_pend;
    logic [15:0] tgt;
    logic [15:0] cnt;
    logic [25:0] pos;
    logic        p_dn;
    logic [15:0] p_tgt;
    logic        p_full;
    logic        p_slat;
    logic [9:0]  cfg;
    logic [15:0] full;
    logic [15:0] slat_t;
    logic [7:0]  angle;
    logic        rly_up;
    logic        rly_dn;
    logic        led_up;
    logic        led_dn;
    logic [31:0] rdata;
    logic        rdy;
    logic        err;
  } bdt_regs_t;

  localparam bdt_regs_t S_RST = '{st: ST_IDLE, cfg: CFG_RST, full: FULL_RST,
                                  slat_t: SLAT_RST, default: '0};

  bdt_regs_t   s;
  bdt_regs_t   n;
  logic        tick;
  logic        acc;
  logic        wr;
  logic        cmd_wr;
  logic        req_stop;
  logic        req_ht;
  logic        req;
  logic        req_dn;
  logic [15:0] req_tgt;
  logic [15:0] ht_tgt;
  logic [15:0] pint;
  logic [25:0] full_fx;
  logic [25:0] dec;
  logic [25:0] pos_nx;
  logic [15:0] cnt_nx;
  logic        run_done;

  bdt_tick #(.TICK_CYC(TICK_CYC)) u_tick (
    .core_clk (core_clk),
    .rst      (rst),
    .tick     (tick)
  );

  function automatic logic [15:0] pause_tk(input logic [2:0] sel);
    int unsigned i;
    i = (sel > 3'h4) ? 4 : int'(sel);
    return 16'(PAUSE_MS[i] / TICK_MS);
  endfunction : pause_tk

  function automatic logic [15:0] stretch_tk(input logic [1:0] sel);
    return 16'(STRETCH_S[sel] * 1000 / TICK_MS);
  endfunction : stretch_tk

  function automatic logic [9:0] slip_k(input logic [3:0] sel);
    return (sel > 4'hc) ? 10'h000 : SLIP_K[sel];
  endfunction : slip_k

  // Slats are closed after lowering, open after raising; turn the rest of the way
  function automatic logic [15:0] slat_tk(input bdt_regs_t r, input logic dn);
    logic [7:0] a;
    a = dn ? r.angle : 8'hff - r.angle;
    return 16'((32'(r.slat_t) * 32'(a)) / 32'hff);
  endfunction : slat_tk

  function automatic logic mapped(input logic [7:0] a);
    return a == REG_CFG || a == REG_FULL || a == REG_SLAT || a == REG_CMD || a == REG_STAT;
  endfunction : mapped

  function automatic bdt_regs_t start_mv(input bdt_regs_t r, input logic dn,
                                         input logic [15:0] tg, input logic fm,
                                         input logic sl, input logic [15:0] p);
    bdt_regs_t q;
    q           = r;
    q.dn        = dn;
    q.tgt       = tg;
    q.full_mv   = fm;
    q.slat_pend = sl;
    // A full raise runs 1/8 over the nominal time so every slip but the largest (1/8, which needs 1/7 over) still reaches the top
    q.cnt       = r.full + {3'h0, r.full[15:3]};
    if (dn && p >= r.full) begin
      q.st  = ST_STEP;
      q.cnt = STEP_TK;
    end else if (!fm && tg == p) begin
      q.st = ST_IDLE;
    end else begin
      q.st = ST_RUN;
    end
    return q;
  endfunction : start_mv

  assign acc      = psel && penable;
  assign wr       = acc && s.rdy && pwrite && !s.err;
  assign cmd_wr   = wr && paddr == REG_CMD;
  assign req_stop = cmd_wr && pwdata[CMD_STOP];
  assign req_ht   = cmd_wr && pwdata[CMD_HEIGHT] && !pwdata[CMD_STOP];
  assign req      = req_ht || (cmd_wr && pwdata[CMD_MOVE] && !pwdata[CMD_STOP])
                    || (!cmd_wr && (btn_up || btn_down));
  assign ht_tgt   = 16'((32'(s.full) * 32'(pwdata[CMD_HT_LSB +: 8])) / 32'hff);
  assign pint     = s.pos[25:FRAC];
  assign req_dn   = req_ht ? (ht_tgt > pint) : (cmd_wr ? pwdata[CMD_DIR] : btn_down);
  assign req_tgt  = req_ht ? ht_tgt : (req_dn ? s.full : 16'h0);
  assign full_fx  = {s.full, {FRAC{1'b0}}};
  // Raising is slower, so with a nonzero slip each raising tick is worth less than one lowering tick
  assign dec      = 26'(1 << FRAC) - 26'(slip_k(s.cfg[CFG_SLIP_LSB +: 4]));

  // Clamp first, so a shortened full running time pulls the position back at once
  always_comb begin
    pos_nx = (s.pos > full_fx) ? full_fx : s.pos;
    if (tick && s.rly_dn) begin
      pos_nx = (pos_nx + 26'(1 << FRAC) > full_fx) ? full_fx : pos_nx + 26'(1 << FRAC);
    end else if (tick && s.rly_up) begin
      pos_nx = (pos_nx > dec) ? pos_nx - dec : 26'h0;
    end
  end

  assign cnt_nx   = (tick && s.cnt != 16'h0) ? s.cnt - 16'h1 : s.cnt;
  assign run_done = s.dn ? (pos_nx[25:FRAC] >= s.tgt)
                         : (s.full_mv ? cnt_nx == 16'h0 : pos_nx[25:FRAC] <= s.tgt);

  always_comb begin
    n     = s;
    n.pos = pos_nx;
    n.cnt = cnt_nx;

    n.rdy = acc && !s.rdy;
    n.err = 1'b0;
    if (acc && !s.rdy) begin
      n.err   = !mapped(paddr);
      n.rdata = 32'h0;
      case (paddr)
        REG_CFG:  n.rdata = {22'h0, s.cfg};
        REG_FULL: n.rdata = {16'h0, s.full};
        REG_SLAT: n.rdata = {8'h0, s.angle, s.slat_t};
        REG_STAT: n.rdata = {8'h0, s.st, s.rly_dn, s.rly_up, pint};
        default:  n.rdata = 32'h0;
      endcase
    end
    if (wr) begin
      case (paddr)
        REG_CFG:  n.cfg = pwdata[9:0];
        REG_FULL: n.full = pwdata[15:0];
        REG_SLAT: begin
          n.slat_t = pwdata[15:0];
          n.angle  = pwdata[23:16];
        end
        default: ;
      endcase
    end

    case (s.st)
      ST_RUN: begin
        if (run_done) begin
          if (s.full_mv && s.dn) begin
            n.st  = ST_STRETCH;
            n.cnt = stretch_tk(s.cfg[CFG_STRETCH_LSB +: 2]);
            if (n.cnt == 16'h0) n.st = ST_IDLE;
          end else if (s.full_mv) begin
            n.st  = ST_IDLE;
            n.pos = 26'h0;
          end else if (s.slat_pend && s.cfg[CFG_AUTO_BIT]) begin
            n.st     = ST_PAUSE;
            n.cnt    = pause_tk(s.cfg[CFG_PAUSE_LSB +: 3]);
            n.p_dn   = !s.dn;
            n.p_slat = 1'b1;
          end else begin
            n.st = ST_IDLE;
          end
        end
      end
      ST_STRETCH, ST_STEP: begin
        if (cnt_nx == 16'h0) n.st = ST_IDLE;
      end
      ST_SLAT: begin
        if (cnt_nx == 16'h0) n.st = ST_IDLE;
      end
      ST_PAUSE: begin
        if (cnt_nx == 16'h0) begin
          if (s.p_slat) begin
            n.st  = ST_SLAT;
            n.dn  = s.p_dn;
            n.cnt = slat_tk(s, s.p_dn);
            if (n.cnt == 16'h0) n.st = ST_IDLE;
          end else begin
            // A height move held over a reversal keeps its slat restoration
            n = start_mv(n, s.p_dn, s.p_tgt, s.p_full, s.slat_pend, pos_nx[25:FRAC]);
          end
        end
      end
      ST_IDLE: ;
      default: n.st = ST_IDLE;
    endcase

    if (req_stop) begin
      n.st = ST_IDLE;
    end else if (req) begin
      if (s.st != ST_IDLE && s.st != ST_PAUSE && s.dn != req_dn) begin
        n.st  = ST_PAUSE;
        n.cnt = pause_tk(s.cfg[CFG_PAUSE_LSB +: 3]);
      end
      if (n.st == ST_PAUSE) begin
        n.p_dn   = req_dn;
        n.p_tgt  = req_tgt;
        n.p_full = !req_ht;
        n.p_slat = 1'b0;
        n.slat_pend = req_ht;
        n.p_slat    = 1'b0;
      end else begin
        n = start_mv(n, req_dn, req_tgt, !req_ht, req_ht, pos_nx[25:FRAC]);
      end
    end
    // One direction bit drives both relays, so they can never be on together
    n.rly_dn = n.dn && (n.st inside {ST_RUN, ST_STRETCH, ST_STEP, ST_SLAT});
    n.rly_up = !n.dn && (n.st inside {ST_RUN, ST_STRETCH, ST_STEP, ST_SLAT});
    n.led_dn = n.rly_dn;
    n.led_up = n.rly_up;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= S_RST;
    end else begin
      s <= n;
    end
  end

  assign prdata     = s.rdata;
  assign pready     = s.rdy;
  assign pslverr    = s.err;
  assign relay_up   = s.rly_up;
  assign relay_down = s.rly_dn;
  assign led_up     = s.led_up;
  assign led_down   = s.led_dn;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  relay_lock_a: assert property (!(relay_up && relay_down))
    else $error("up and down relays energised together");
  led_track_a: assert property (led_up == relay_up && led_down == relay_down)
    else $error("direction LED disagrees with relay");
  pause_entry_a: assert property ($rose(s.st == ST_PAUSE) |->
      s.cnt == pause_tk(s.cfg[CFG_PAUSE_LSB +: 3]) && !relay_up && !relay_down)
    else $error("reversal pause wrong length or relay still on");
  step_len_a: assert property ($rose(s.st == ST_STEP) |-> s.cnt == STEP_TK && relay_down)
    else $error("lower-end step not 100 ms on the down relay");
  stretch_len_a: assert property ($rose(s.st == ST_STRETCH) |->
      s.cnt == stretch_tk(s.cfg[CFG_STRETCH_LSB +: 2]) && relay_down)
    else $error("stretch-out time wrong");
  pos_clamp_a: assert property (s.pos <= {s.full, {FRAC{1'b0}}} || $changed(s.full))
    else $error("position beyond full running time");
  down_count_a: assert property (tick && relay_down && s.pos + 26'(1 << FRAC) <= full_fx
      |=> s.pos == $past(s.pos) + 26'(1 << FRAC))
    else $error("lowering tick not counted as one tick");
  up_slip_a: assert property (tick && relay_up && s.pos > dec
      |=> s.pos == $past(s.pos) - $past(dec))
    else $error("raising tick not scaled by slippage");
  top_reset_a: assert property (s.st == ST_RUN && s.full_mv && !s.dn && run_done
      && !req && !req_stop |=> s.pos == 26'h0 && s.st == ST_IDLE)
    else $error("full raise did not zero the position");

  reverse_c: cover property (s.st == ST_PAUSE ##1 s.st == ST_RUN);
  slat_c: cover property (s.st == ST_SLAT);
  step_c: cover property (s.st == ST_STEP);
  stretch_c: cover property (s.st == ST_STRETCH ##1 s.st == ST_IDLE);

endmodule : bdt_travel

// [verif/bdt_motor.sv]
`timescale 1ns/1ns
module bdt_motor (
  input  wire logic core_clk,
  input  wire logic relay_up,
  input  wire logic relay_down,
  output logic      jam
);
  // Both windings fed at once would burn a real motor, so the model latches it
  initial jam = 1'b0;
  always @(posedge core_clk) begin
    if (relay_up && relay_down) jam <= 1'b1;
  end
endmodule : bdt_motor

// [verif/testbench.sv]
`timescale 1ns/1ns
module testbench;
  import bdt_pkg::*;
  localparam int TK = 10;
  localparam int F  = 40;
  typedef struct {logic [1:0] kind; logic [31:0] lo, hi, mask; logic err;} bdt_note_t;
  logic        core_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic        btn_up, btn_down, relay_up, relay_down, led_up, led_down, jam;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  int          fail_count, n_tests, up_cnt, dn_cnt, cyc, t_off, p, s, k, pt, p1, t2;
  bdt_note_t   notes[$];

  bdt_travel #(.TICK_CYC(TK)) dut (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .btn_up(btn_up), .btn_down(btn_down),
    .relay_up(relay_up), .relay_down(relay_down), .led_up(led_up), .led_down(led_down));
  bdt_motor motor (.core_clk(core_clk), .relay_up(relay_up), .relay_down(relay_down),
    .jam(jam));

  always #50 core_clk = ~core_clk;

  task automatic give_verdict;
    if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic note(input logic [1:0] kd, input int lo, input int hi,
                      input logic [31:0] m, input logic e);
    notes.push_back('{kd, 32'(lo), 32'(hi), m, e});
  endtask : note

  // Timed intervals may end up to two ticks early or one tick late
  task automatic run(input logic [1:0] kd, input int t);
    note(kd, (t - 2) * TK, (t + 1) * TK, '1, 1'b0);
  endtask : run

  task automatic take(input logic [1:0] kd, input logic [31:0] v, input logic e);
    bdt_note_t n;
    if (notes.size() == 0) begin
      fail_count++;
      $display("BAD t=%0t unexpected result", $time);
    end else begin
      n = notes.pop_front();
      chk(32'(kd), 32'(n.kind));
      chk(32'((v & n.mask) >= n.lo && (v & n.mask) <= n.hi), 32'h1);
      chk(32'(e), 32'(n.err));
    end
  endtask : take

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input int lo, input int hi,
                    input logic [31:0] m, input logic e);
    note(2'd0, lo, hi, m, e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic press(input logic dn);
    if (dn) btn_down <= 1'b1;
    else btn_up <= 1'b1;
    @(posedge core_clk);
    btn_down <= 1'b0;
    btn_up <= 1'b0;
    @(posedge core_clk);
  endtask : press

  // Quiet span outlasts the longest reversal pause, so a pending move is not missed
  task automatic wait_idle;
    int quiet, n;
    quiet = 0;
    n = 0;
    while (quiet < 1400 && n < 40000) begin
      @(posedge core_clk);
      n++;
      quiet = (relay_up === 1'b0 && relay_down === 1'b0) ? quiet + 1 : 0;
    end
    chk(32'(quiet >= 1400), 32'h1);
  endtask : wait_idle

  function automatic logic [31:0] cfg(input int ps, input int sl, input int st, input int au);
    return 32'(ps) | (32'(sl) << CFG_SLIP_LSB) | (32'(st) << CFG_STRETCH_LSB)
           | (32'(au) << CFG_AUTO_BIT);
  endfunction : cfg

  function automatic logic [31:0] ht(input logic [7:0] h);
    return (32'h1 << CMD_HEIGHT) | (32'(h) << CMD_HT_LSB);
  endfunction : ht

  always @(posedge core_clk) begin
    if (rst) begin
      up_cnt = 0;
      dn_cnt = 0;
      cyc = 0;
      t_off = 0;
    end else begin
      cyc++;
      chk(32'(led_up), 32'(relay_up));
      chk(32'(led_down), 32'(relay_down));
      chk(32'(relay_up & relay_down), 32'h0);
      if (pready === 1'b1 && pwrite === 1'b0) take(2'd0, prdata, pslverr);
      if (relay_down === 1'b1) dn_cnt++;
      else if (dn_cnt != 0) begin
        take(2'd1, 32'(dn_cnt), 1'b0);
        dn_cnt = 0;
        t_off = cyc;
      end
      if (relay_up === 1'b1) begin
        if (up_cnt == 0 && notes.size() != 0 && notes[0].kind == 2'd3)
          take(2'd3, 32'(cyc - t_off), 1'b0);
        up_cnt++;
      end else if (up_cnt != 0) begin
        take(2'd2, 32'(up_cnt), 1'b0);
        up_cnt = 0;
      end
    end
  end

  initial begin
    repeat (98000) @(posedge core_clk);
    fail_count++;
    give_verdict();
  end

  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    {psel, penable, pwrite, btn_up, btn_down} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fail_count = 0;
    n_tests = 0;
    void'($urandom(32'hab911991));
    p = $urandom_range(4, 0);
    s = $urandom_range(12, 9);
    k = SLIP_K[s];
    pt = PAUSE_MS[p] / TICK_MS;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(REG_CFG, CFG_RST, CFG_RST, '1, 1'b0);
    rd(REG_FULL, FULL_RST, FULL_RST, '1, 1'b0);
    rd(REG_SLAT, SLAT_RST, SLAT_RST, '1, 1'b0);
    rd(REG_CMD, 0, 0, '1, 1'b0);
    rd(REG_STAT, 32'h40000, 32'h40000, '1, 1'b0);
    rd(8'h14, 0, 0, '1, 1'b1);
    apb(1'b1, REG_FULL, 32'(F));
    apb(1'b1, REG_SLAT, 32'h14);
    for (int st = 0; st < 4; st++) begin
      apb(1'b1, REG_CFG, cfg(p, 0, st, 0));
      run(2'd1, F + STRETCH_S[st] * 100);
      apb(1'b1, REG_CMD, 32'h3);
      wait_idle();
      rd(REG_STAT, F, F, 32'hffff, 1'b0);
      run(2'd1, STEP_MS / TICK_MS);
      press(1'b1);
      wait_idle();
      run(2'd2, F + F / 8);
      press(1'b0);
      wait_idle();
      rd(REG_STAT, 32'h40000, 32'h40000, '1, 1'b0);
    end
    apb(1'b1, REG_CFG, cfg(p, 0, 0, 0));
    note(2'd1, 8 * TK, 14 * TK, '1, 1'b0);
    note(2'd3, (pt - 1) * TK, (pt + 1) * TK + 20, '1, 1'b0);
    note(2'd2, 1, 50 * TK, '1, 1'b0);
    apb(1'b1, REG_CMD, 32'h3);
    repeat (100) @(posedge core_clk);
    apb(1'b1, REG_CMD, 32'h1);
    wait_idle();
    // Lower to half with slip on and no slat move, then raise to a quarter against the slip
    apb(1'b1, REG_CFG, cfg(p, s, 0, 0));
    note(2'd1, 19 * TK, 23 * TK, '1, 1'b0);
    apb(1'b1, REG_CMD, ht(8'h80));
    wait_idle();
    rd(REG_STAT, 20, 21, 32'hffff, 1'b0);
    p1 = F * 128 * 1024 / 255;
    t2 = F * 64 * 1024 / 255;
    note(2'd2, ((p1 - t2) / (1024 - k) - 1) * TK,
         ((p1 + 1024 - t2) / (1024 - k) + 2) * TK, '1, 1'b0);
    apb(1'b1, REG_CMD, ht(8'h40));
    wait_idle();
    rd(REG_STAT, 9, 11, 32'hffff, 1'b0);
    apb(1'b1, REG_CFG, cfg(p, s, 0, 1));
    note(2'd1, 1, 40 * TK, '1, 1'b0);
    note(2'd3, (pt - 1) * TK, (pt + 1) * TK + 20, '1, 1'b0);
    run(2'd2, 20);
    apb(1'b1, REG_CMD, ht(8'hc0));
    wait_idle();
    // Stop wins at once; then a height move cut by a reversal still turns the slats
    note(2'd1, 50, 58, '1, 1'b0);
    apb(1'b1, REG_CMD, 32'h3);
    repeat (50) @(posedge core_clk);
    apb(1'b1, REG_CMD, 32'h8);
    wait_idle();
    apb(1'b1, REG_SLAT, 32'h800014);
    note(2'd1, 30, 40, '1, 1'b0);
    note(2'd3, (pt - 1) * TK, (pt + 1) * TK + 20, '1, 1'b0);
    note(2'd2, 1, 50 * TK, '1, 1'b0);
    run(2'd1, 20 * 128 / 255);
    apb(1'b1, REG_CMD, ht(8'hff));
    repeat (30) @(posedge core_clk);
    apb(1'b1, REG_CMD, ht(8'h00));
    wait_idle();
    chk(32'(jam), 32'h0);
    chk(32'(notes.size()), 32'h0);
    give_verdict();
  end
endmodule : testbench
